// ===== ssp_core.sv
// subtract and special-page datapath: work register, status flags and special page store
`timescale 1ns/100ps

// Notes on behaviour
// - register subtract with borrow: file value plus inverted work plus borrow, one cycle
// - destination select 0 writes work register, 1 writes back to file register, for the two register subtracts only
// - immediate subtract with borrow lands in work register, flags updated, one cycle
// - write page copies work register into page entry 0 to 21, flags untouched
// - read page copies page entry 0 to 21 into work register, flags untouched
// - plain register subtract: file value minus work register, no borrow in
module ssp_core
   import ssp_pkg::*;
(
   input  wire logic                  clock,
   input  wire logic                  reset,
   input  wire logic                  op_valid,
   input  wire ssp_op_t               op_code,
   input  wire logic [FILE_ADDR_W-1:0] file_addr,
   input  wire logic [DATA_W-1:0]     file_rdata,
   input  wire logic                  dest_sel,
   input  wire logic [DATA_W-1:0]     imm_value,
   input  wire logic [PAGE_IDX_W-1:0] page_idx,
   output logic                       op_done,
   output logic                       op_bad,
   output logic                       file_we_ff,
   output logic [FILE_ADDR_W-1:0]     file_waddr_ff,
   output logic [DATA_W-1:0]          file_wdata_ff,
   output logic [DATA_W-1:0]          work_register_ff,
   output logic                       result_nil_bit_ff,
   output logic                       nibble_borrow_bit_ff,
   output logic                       borrow_bit_ff
);
   // ----------------------------------------------------------------
   // operand selection
   // ----------------------------------------------------------------
   // special page store; indices above the last entry are refused upstream
   logic [DATA_W-1:0] page_ff [PAGE_DEPTH];
   logic [DATA_W-1:0] sub_a;
   logic              sub_cin;
   logic [DATA_W-1:0] sub_q;
   logic              sub_nib;
   logic              sub_byte;
   logic              sub_zero;
   logic              is_sub;
   logic              to_file;
   logic              idx_ok;
   logic              imm_ok;
   logic              accept;
   // retire qualifiers, each already gated by op_done
   logic              sub_to_work;
   logic              sub_to_file;
   logic              flag_upd;
   logic              page_wr;
   logic              page_rd;

   // one range compare shared by both page forms, so their limits cannot
   // drift apart
   function automatic logic page_in_range(input logic [PAGE_IDX_W-1:0] idx);
      return idx <= PAGE_IDX_MAX;
   endfunction

   // file address is 7 bits wide so 0..FILE_ADDR_MAX is always covered
   assign idx_ok = page_in_range(page_idx);
   // the immediate form rejects 255, the one value left out of its range
   assign imm_ok = (imm_value != IMM_LIMIT);

   // pick minuend and borrow input per operation
   always_comb begin
      // defaults serve the plain register subtract
      sub_a   = file_rdata;
      sub_cin = 1'b1;
      is_sub  = 1'b0;
      accept  = 1'b0;
      case (op_code)
         SSP_OP_SUB_BORROW_REG: begin
            sub_cin = borrow_bit_ff;
            is_sub  = 1'b1;
            accept  = 1'b1;
         end
         SSP_OP_SUB_BORROW_IMM: begin
            sub_a   = imm_value;
            sub_cin = borrow_bit_ff;
            is_sub  = imm_ok;
            accept  = imm_ok;
         end
         SSP_OP_SUB_REG: begin
            is_sub  = 1'b1;
            accept  = 1'b1;
         end
         SSP_OP_WRITE_PAGE: begin
            accept  = idx_ok;
         end
         SSP_OP_READ_PAGE: begin
            accept  = idx_ok;
         end
         default: begin
            accept  = 1'b0;
         end
      endcase
   end

   // one shared subtractor serves all three subtract forms; only the minuend
   // and borrow input differ between them, so no second adder is spent
   ssp_sub_unit ssp_sub_unit_inst (
      .minuend      (sub_a),
      .subtrahend   (work_register_ff),
      .carry_in     (sub_cin),
      .diff         (sub_q),
      .nibble_carry (sub_nib),
      .byte_carry   (sub_byte),
      .is_zero      (sub_zero)
   );

   // ----------------------------------------------------------------
   // handshake
   // ----------------------------------------------------------------
   // every accepted operation retires in the same cycle it is issued
   assign op_done = op_valid & accept;
   // op_bad lets the decoder trap a refused request; a none code is an idle
   // slot and is neither done nor bad
   assign op_bad  = op_valid & ~accept & (op_code != SSP_OP_NONE);
   // immediate form always targets the work register
   assign to_file = (op_code != SSP_OP_SUB_BORROW_IMM) & (dest_sel == DEST_FILE);

   // ----------------------------------------------------------------
   // retire decode
   // ----------------------------------------------------------------
   // every qualifier folds in op_done, so a refused or idle cycle can never
   // reach one of the registers below
   assign sub_to_work = op_done & is_sub & ~to_file;
   assign sub_to_file = op_done & is_sub & to_file;
   assign flag_upd    = op_done & is_sub;
   assign page_wr     = op_done & (op_code == SSP_OP_WRITE_PAGE);
   assign page_rd     = op_done & (op_code == SSP_OP_READ_PAGE);

   // ----------------------------------------------------------------
   // work register
   // ----------------------------------------------------------------
   // subtract results and page reads are exclusive by op code, so the
   // order of the two branches below never matters
   always_ff @(posedge clock) begin
      if (reset) begin
         work_register_ff <= WORK_RST;
      end else if (sub_to_work) begin
         work_register_ff <= sub_q;
      end else if (page_rd) begin
         work_register_ff <= page_ff[page_idx];
      end
   end

   // ----------------------------------------------------------------
   // file write-back port
   // ----------------------------------------------------------------
   // one-cycle write strobe; the register file outside commits it
   always_ff @(posedge clock) begin
      if (reset) begin
         file_we_ff <= 1'b0;
      end else begin
         file_we_ff <= sub_to_file;
      end
   end

   // address and data hold after the strobe drops, so the register file
   // need not catch them in the strobe cycle alone
   always_ff @(posedge clock) begin
      if (reset) begin
         file_waddr_ff <= '0;
         file_wdata_ff <= 8'h00;
      end else if (sub_to_file) begin
         file_waddr_ff <= file_addr;
         file_wdata_ff <= sub_q;
      end
   end

   // ----------------------------------------------------------------
   // status flags
   // ----------------------------------------------------------------
   // page moves leave flags alone, only subtracts touch them; each flag has
   // its own process so a change to one cannot disturb the others
   // nil flag: set on an all-zero byte result, whatever its destination
   always_ff @(posedge clock) begin
      if (reset) begin
         result_nil_bit_ff <= FLAG_RST;
      end else if (flag_upd) begin
         result_nil_bit_ff <= sub_zero;
      end
   end

   // nibble flag: carry out of bit 3, so 1 means the low nibble did not borrow
   always_ff @(posedge clock) begin
      if (reset) begin
         nibble_borrow_bit_ff <= FLAG_RST;
      end else if (flag_upd) begin
         nibble_borrow_bit_ff <= sub_nib;
      end
   end

   // borrow flag: carry out of bit 7; it also feeds the next borrow subtract,
   // so a back-to-back chain sees the updated value one cycle later
   always_ff @(posedge clock) begin
      if (reset) begin
         borrow_bit_ff <= FLAG_RST;
      end else if (flag_upd) begin
         borrow_bit_ff <= sub_byte;
      end
   end

   // ----------------------------------------------------------------
   // special page store
   // ----------------------------------------------------------------
   // out-of-range indices never get here since accept is low for them, so
   // the 5-bit index cannot write past the last entry
   always_ff @(posedge clock) begin
      if (reset) begin
         for (int i = 0; i < PAGE_DEPTH; i++) begin
            page_ff[i] <= PAGE_RST;
         end
      end else if (page_wr) begin
         page_ff[page_idx] <= work_register_ff;
      end
   end
endmodule

// ===== ssp_pkg.sv
// package: opcodes, widths, ranges and reset values for the subtract and special-page datapath
package ssp_pkg;
   localparam int unsigned DATA_W         = 8;
   localparam int unsigned FILE_ADDR_W    = 7;
   localparam int unsigned PAGE_IDX_W     = 5;
   localparam int unsigned PAGE_DEPTH     = 22;   // special page indices 0 to 21
   localparam logic [6:0]  FILE_ADDR_MAX  = 7'h7F; // file register addresses 0 to 127
   localparam logic [4:0]  PAGE_IDX_MAX   = 5'h15; // last special page index, 21
   localparam logic [7:0]  IMM_LIMIT      = 8'hFF; // immediates must stay below 255
   localparam logic        DEST_WORK      = 1'h0;
   localparam logic        DEST_FILE      = 1'h1;
   localparam logic [7:0]  WORK_RST       = 8'h00;
   localparam logic [7:0]  PAGE_RST       = 8'h00;
   localparam logic        FLAG_RST       = 1'h0;
   localparam int unsigned EXEC_CYCLES    = 1;    // every operation here completes in one cycle

   typedef enum logic [2:0] {
      SSP_OP_NONE,
      SSP_OP_SUB_BORROW_REG,
      SSP_OP_SUB_BORROW_IMM,
      SSP_OP_WRITE_PAGE,
      SSP_OP_READ_PAGE,
      SSP_OP_SUB_REG
   } ssp_op_t;
endpackage

// ===== ssp_sub_unit.sv
// subtractor leaf: a + ~b + carry_in with nibble and byte carry outs
`timescale 1ns/100ps
module ssp_sub_unit
   import ssp_pkg::*;
(
   input  wire logic [7:0] minuend,
   input  wire logic [7:0] subtrahend,
   input  wire logic       carry_in,
   output logic      [7:0] diff,
   output logic            nibble_carry,
   output logic            byte_carry,
   output logic            is_zero
);
   logic [4:0] low_sum;
   logic [4:0] high_sum;

   // carry out of each nibble is "no borrow", matching the flag sense
   always_comb begin
      low_sum      = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, carry_in};
      high_sum     = {1'b0, minuend[7:4]} + {1'b0, ~subtrahend[7:4]} + {4'h0, low_sum[4]};
      diff         = {high_sum[3:0], low_sum[3:0]};
      nibble_carry = low_sum[4];
      byte_carry   = high_sum[4];
      is_zero      = (diff == 8'h00);
   end
endmodule

// ===== ssp_core_assertions.sv
// checker: port-level properties of the subtract and special-page datapath
`timescale 1ns/100ps
module ssp_core_checker
   import ssp_pkg::*;
(
   input wire logic       clock,
   input wire logic       reset,
   input wire logic       op_valid,
   input wire ssp_op_t    op_code,
   input wire logic [6:0] file_addr,
   input wire logic [7:0] file_rdata,
   input wire logic       dest_sel,
   input wire logic [7:0] imm_value,
   input wire logic [4:0] page_idx,
   input wire logic       op_done,
   input wire logic       op_bad,
   input wire logic       file_we_ff,
   input wire logic [6:0] file_waddr_ff,
   input wire logic [7:0] file_wdata_ff,
   input wire logic [7:0] work_register_ff,
   input wire logic       result_nil_bit_ff,
   input wire logic       nibble_borrow_bit_ff,
   input wire logic       borrow_bit_ff
);
   // ----
   // properties
   // ----
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // an accepted operation of one kind
   sequence took(k);
      op_done && op_code == k;
   endsequence
   imm_refuse_a: assert property (op_valid && op_code == SSP_OP_SUB_BORROW_IMM
      && imm_value == 8'hFF |-> op_bad && !op_done) else $error("bad immediate taken");
   page_refuse_a: assert property (op_valid && page_idx > PAGE_IDX_MAX
      && op_code inside {SSP_OP_WRITE_PAGE, SSP_OP_READ_PAGE}
      |-> op_bad && !op_done ##1 $stable(work_register_ff)) else $error("bad index taken");
   dest_file_a: assert property (op_done && op_code == SSP_OP_SUB_REG && dest_sel
      |=> file_we_ff && file_waddr_ff == $past(file_addr) && $stable(work_register_ff))
      else $error("file write back missing");
   dest_work_a: assert property (op_done && op_code == SSP_OP_SUB_BORROW_REG
      && !dest_sel |=> !file_we_ff) else $error("stray file write");
   we_pulse_a: assert property (!(op_done && dest_sel
      && op_code inside {SSP_OP_SUB_REG, SSP_OP_SUB_BORROW_REG}) |=> !file_we_ff)
      else $error("write strobe without a file subtract");
   nibble_flag_a: assert property (took(SSP_OP_SUB_REG)
      |=> nibble_borrow_bit_ff == ($past(file_rdata[3:0]) >= $past(work_register_ff[3:0])))
      else $error("nibble borrow sense wrong");
   sub_plain_a: assert property (op_done && op_code == SSP_OP_SUB_REG && !dest_sel
      |=> work_register_ff == 8'($past(file_rdata) - $past(work_register_ff)))
      else $error("plain subtract wrong");
   sub_borrow_a: assert property (op_done && op_code == SSP_OP_SUB_BORROW_REG && dest_sel
      |=> file_wdata_ff == 8'($past(file_rdata) + ~$past(work_register_ff)
      + $past(borrow_bit_ff))) else $error("borrow subtract wrong");
   no_borrow_a: assert property (took(SSP_OP_SUB_REG)
      |=> borrow_bit_ff == ($past(file_rdata) >= $past(work_register_ff)))
      else $error("borrow sense wrong");
   nil_flag_a: assert property (took(SSP_OP_SUB_BORROW_IMM)
      |=> result_nil_bit_ff == (work_register_ff == 8'h00)) else $error("nil flag wrong");
   flag_keep_a: assert property (op_done && op_code inside {SSP_OP_WRITE_PAGE,
      SSP_OP_READ_PAGE} |=> $stable({result_nil_bit_ff, nibble_borrow_bit_ff, borrow_bit_ff}))
      else $error("page move touched flags");
endmodule

bind ssp_core ssp_core_checker ssp_core_checker_inst (.*);

// ===== subtract_and_special_page_ops_tb.sv
// testbench: directed operations on the subtract and special-page datapath
`timescale 1ns/100ps
module subtract_and_special_page_ops_tb
   import ssp_pkg::*;
;
   logic       clock, reset, op_valid, dest_sel, done_s, bad_s;
   ssp_op_t    op_code;
   logic [6:0] file_addr;
   logic [7:0] file_rdata, imm_value;
   logic [4:0] page_idx;
   wire logic  op_done, op_bad, file_we_ff, result_nil_bit_ff, nibble_borrow_bit_ff, borrow_bit_ff;
   wire logic [6:0] file_waddr_ff;
   wire logic [7:0] file_wdata_ff, work_register_ff;
   int         errors, cmp_count;
   // ----
   // harness
   // ----
   ssp_core ssp_core_inst (.*);
   initial begin
      clock = 0;
      forever #4 clock = ~clock;
   end
   task automatic chk(string n, logic [7:0] s, logic [7:0] e);
      cmp_count++;
      if (s !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   // one request held for a full cycle; combinational answers caught before the edge
   task automatic op(ssp_op_t c, logic [6:0] a, logic [7:0] r, logic d, logic [7:0] i,
                     logic [4:0] p);
      @(negedge clock);
      op_code = c;
      {op_valid, file_addr, file_rdata, dest_sel, imm_value, page_idx} = {1'b1, a, r, d, i, p};
      #1;
      done_s = op_done;
      bad_s = op_bad;
      @(negedge clock);
      op_valid = 0;
   endtask
   function automatic logic [7:0] flags();
      return {5'h00, result_nil_bit_ff, nibble_borrow_bit_ff, borrow_bit_ff};
   endfunction
   task automatic t_imm;
      op(SSP_OP_SUB_BORROW_IMM, 7'h00, 8'h00, 1'b0, 8'h06, 5'h00);
      chk("done", done_s, 8'h01);
      chk("work", work_register_ff, 8'h05);
      chk("flags", flags(), 8'h03);
      op(SSP_OP_SUB_BORROW_IMM, 7'h00, 8'h00, 1'b0, 8'hFF, 5'h00);
      chk("bad", bad_s, 8'h01);
      chk("done", done_s, 8'h00);
      chk("work", work_register_ff, 8'h05);
      op(SSP_OP_SUB_REG, 7'h01, 8'h10, 1'b0, 8'h00, 5'h00);
      chk("work", work_register_ff, 8'h0B);
      chk("flags", flags(), 8'h01);
      op(SSP_OP_SUB_REG, 7'h01, 8'h10, 1'b0, 8'h00, 5'h00);
      chk("work", work_register_ff, 8'h05);
   endtask
   task automatic t_reg;
      op(SSP_OP_SUB_REG, 7'h7F, 8'h06, 1'b1, 8'h00, 5'h00);
      chk("we", file_we_ff, 8'h01);
      chk("waddr", file_waddr_ff, 8'h7F);
      chk("wdata", file_wdata_ff, 8'h01);
      chk("work", work_register_ff, 8'h05);
      op(SSP_OP_SUB_REG, 7'h11, 8'h04, 1'b0, 8'h00, 5'h00);
      chk("work", work_register_ff, 8'hFF);
      chk("we", file_we_ff, 8'h00);
      chk("flags", flags(), 8'h00);
      op(SSP_OP_SUB_BORROW_REG, 7'h00, 8'h05, 1'b0, 8'h00, 5'h00);
      chk("work", work_register_ff, 8'h05);
      chk("flags", flags(), 8'h00);
      op(SSP_OP_SUB_BORROW_REG, 7'h22, 8'h06, 1'b1, 8'h00, 5'h00);
      chk("wdata", file_wdata_ff, 8'h00);
      chk("flags", flags(), 8'h07);
      op(SSP_OP_SUB_BORROW_REG, 7'h7F, 8'h06, 1'b1, 8'h00, 5'h00);
      chk("wdata", file_wdata_ff, 8'h01);
   endtask
   task automatic t_page;
      op(SSP_OP_WRITE_PAGE, 7'h00, 8'h00, 1'b0, 8'h00, 5'h15);
      chk("flags", flags(), 8'h03);
      op(SSP_OP_SUB_BORROW_IMM, 7'h00, 8'h00, 1'b0, 8'h06, 5'h00);
      op(SSP_OP_READ_PAGE, 7'h00, 8'h00, 1'b0, 8'h00, 5'h15);
      chk("work", work_register_ff, 8'h05);
      chk("flags", flags(), 8'h03);
      op(SSP_OP_READ_PAGE, 7'h00, 8'h00, 1'b0, 8'h00, 5'h16);
      chk("bad", bad_s, 8'h01);
      op(SSP_OP_WRITE_PAGE, 7'h00, 8'h00, 1'b0, 8'h00, 5'h16);
      chk("bad", bad_s, 8'h01);
      op(SSP_OP_READ_PAGE, 7'h00, 8'h00, 1'b0, 8'h00, 5'h00);
      chk("work", work_register_ff, 8'h00);
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // watchdog: the whole run needs well under a thousand cycles
   initial begin
      #20000;
      errors++;
      finish_test;
   end
   initial begin
      op_code = SSP_OP_NONE;
      {op_valid, file_addr, file_rdata, dest_sel, imm_value, page_idx} = '0;
      reset = 1;
      repeat (3) @(negedge clock);
      reset = 0;
      t_imm;
      t_reg;
      t_page;
      finish_test;
   end
endmodule
